// ### hdl/flpw_entry_chk.sv
// entry checker: present, reserved bits and rights of one table entry
`timescale 1ns/1ns
module flpw_entry_chk (
  input wire logic [63:0] entry, // fetched entry
  input wire logic [5:0] phys_width, // phys_addr_width
  input wire logic nx_enable, // no_execute_enable
  input wire logic size_rsvd, // page_size_flag is reserved here
  input wire logic big_page, // entry maps a 1-GByte page
  output logic bad, // not present or reserved bit set
  output logic wr_ok, // write_allow_flag
  output logic usr_ok, // user_access_flag
  output logic nx // no_execute_flag in force
);
  logic [51:0] hi_mask; // ones at bits 51:phys_addr_width

  // reserved and present check
  always_comb begin
    hi_mask = ~((52'h1 << phys_width) - 52'h1);
    bad = ~entry[flpw_pkg::ENT_PRESENT_BIT];
    if ((entry[51:0] & hi_mask & 52'hF_FFFF_FFFF_F000) != 52'h0) begin
      bad = 1'b1; // R14 R6
    end
    if (size_rsvd && entry[flpw_pkg::ENT_SIZE_BIT]) begin
      bad = 1'b1; // R13 R14
    end
    if (big_page && (entry[29:13] != 17'h0_0000)) begin
      bad = 1'b1; // reserved field of a 1-GByte mapping
    end
    if (!nx_enable && entry[flpw_pkg::ENT_NX_BIT]) begin
      bad = 1'b1; // R18
    end
    wr_ok = entry[flpw_pkg::ENT_WRITE_BIT]; // R15 R20
    usr_ok = entry[flpw_pkg::ENT_USER_BIT]; // R16
    nx = nx_enable & entry[flpw_pkg::ENT_NX_BIT]; // R18
  end
endmodule : flpw_entry_chk

// ### hdl/flpw_pkg.sv
// package: constants, types and state encodings for the four-level page walker
package flpw_pkg;
  localparam int LIN_W = 48; // linear address width
  localparam int PHY_W = 52; // widest physical address
  localparam int IDX_W = 9; // table index width, 512 entries per table
  // root pointer fields
  localparam int ROOT_WT_BIT = 3;
  localparam int ROOT_CD_BIT = 4;
  localparam int ROOT_TAG_HI = 11;
  localparam logic [63:0] ROOT_RESET = 64'h0000_0000_0000_0000;
  // entry fields
  localparam int ENT_PRESENT_BIT = 0;
  localparam int ENT_WRITE_BIT = 1;
  localparam int ENT_USER_BIT = 2;
  localparam int ENT_WT_BIT = 3;
  localparam int ENT_CD_BIT = 4;
  localparam int ENT_ACCESSED_BIT = 5;
  localparam int ENT_SIZE_BIT = 7;
  localparam int ENT_NX_BIT = 63;
  // linear address index positions
  localparam int TOP_IDX_LO = 39;
  localparam int THIRD_IDX_LO = 30;
  localparam int DIR_IDX_LO = 21;
  localparam int OFS_1G_W = 30;
  localparam int OFS_2M_W = 21;
  // user privilege level
  localparam logic [1:0] USER_LEVEL = 2'h3;
  // fault levels
  localparam logic [1:0] LVL_TOP = 2'h0;
  localparam logic [1:0] LVL_THIRD = 2'h1;
  localparam logic [1:0] LVL_DIR = 2'h2;

  // walker states
  typedef enum logic [2:0] {
    FLPW_IDLE = 3'b000,
    FLPW_TOP = 3'b001,
    FLPW_THIRD = 3'b010,
    FLPW_DIR = 3'b011,
    FLPW_DONE = 3'b100,
    FLPW_FAULT = 3'b101
  } flpw_state_e;

  // translation request from the address-generation side
  typedef struct packed {
    logic [47:0] lin_addr; // linear address
    logic is_write; // write access
    logic is_fetch; // instruction fetch
    logic [1:0] priv_level; // privilege_level of the access
  } flpw_req_s;

  // translation result
  typedef struct packed {
    logic [51:0] phys_addr; // physical address
    logic [1:0] page_size; // 0 none, 1 2-MByte, 2 1-GByte
    logic fault; // walk ended in translation fault
    logic denied; // access rights refused the access
    logic [1:0] fault_level; // level at which the walk stopped
  } flpw_rsp_s;

  // memory fetch request
  typedef struct packed {
    logic [51:0] addr; // entry address
    logic wr_thru; // write-through attribute for this fetch
    logic cache_off; // cache-disable attribute for this fetch
    logic set_accessed; // request that bit 5 be written back as one
  } flpw_mem_s;
endpackage : flpw_pkg

// ### hdl/flpw_walker.sv
// four-level page walker: root pointer register, walk sequencer, result
// Operation
// R1: walk only with all three enables set
// R2: 48-bit linear in, up to 52-bit physical
// R3: untagged root: bits 3,4 attributes, base
// R4: tagged root: bits 11:0 are context tag
// R5: layout follows tag enable immediately; tag zeroed
// R6: bits above phys_addr_width always zero
// R7: 4-KByte, 2-MByte pages; 1-GByte optional
// R8: top entry address from root and 47:39
// R9: tables 4-KByte aligned, 512 eight-byte entries
// R10: third entry address from top entry, 38:30
// R11: size flag ends walk with 1-GByte page
// R12: else directory address from entry, 29:21
// R13: no 1-GByte support: size bit reserved
// R14: top entry present, bit 7 reserved
// R15: clear write flag may refuse writes
// R16: clear user flag refuses level 3
// R17: bit 5 records entry was used
// R18: no-execute flag blocks fetches or reserved
// R19: entry bits 3,4 steer next fetch type
// R20: 1-GByte mapping present; bit 1 write
// R21: directory size flag ends with 2-MByte
// R22: absent or reserved entry faults, level reported
`timescale 1ns/1ns
module flpw_walker #(
  parameter bit GIG_PAGES = 1'b1 // 1-GByte pages supported
) (
  input wire logic clk_sys, // 10 MHz clock
  input wire logic rst_b, // async reset, active low
  input wire logic paging_enable, // paging on
  input wire logic extended_addr_enable, // extended addressing on
  input wire logic long_mode_enable, // long mode on
  input wire logic context_tag_enable, // root pointer carries context tag
  input wire logic no_execute_enable, // no-execute flag in force
  input wire logic supervisor_write_protect, // supervisor honours write flag
  input wire logic [5:0] phys_addr_width, // physical address width
  input wire logic root_wr, // write strobe for root pointer
  input wire logic [63:0] root_wdata, // new root pointer value
  output logic [63:0] root_pointer_reg, // root pointer readback
  output logic [11:0] context_tag, // current context tag
  output logic walker_active, // four-level scheme in use
  input wire logic req_valid, // translation request
  output logic req_ready, // walker accepts request
  input wire flpw_pkg::flpw_req_s req, // request fields
  output logic rsp_valid, // result pulse
  output flpw_pkg::flpw_rsp_s rsp, // result fields
  output logic mem_valid, // entry fetch request
  input wire logic mem_ready, // memory took the fetch
  output flpw_pkg::flpw_mem_s mem, // fetch address and attributes
  input wire logic mem_rvalid, // entry data returned
  input wire logic [63:0] mem_rdata // entry data
);
  // whole state of the walker
  typedef struct packed {
    flpw_pkg::flpw_state_e st; // sequencer state
    logic [63:0] root; // root pointer
    flpw_pkg::flpw_req_s rq; // held request
    logic [51:0] base; // current table base
    logic wr_thru; // write-through for the next fetch
    logic cache_off; // cache-disable for the next fetch
    logic issued; // fetch accepted, waiting for data
    logic wr_ok; // accumulated write permission
    logic usr_ok; // accumulated user permission
    logic nx; // accumulated no-execute
    flpw_pkg::flpw_rsp_s out; // result register
    logic out_valid; // result pulse
  } flpw_state_s;

  flpw_state_s s_reg; // registered state
  flpw_state_s s_next; // next state
  logic [51:0] addr_mask; // ones below phys_addr_width
  logic [8:0] idx; // index of the current level
  logic chk_bad; // entry fault
  logic chk_wr; // entry write flag
  logic chk_usr; // entry user flag
  logic chk_nx; // entry no-execute
  logic size_rsvd; // size flag reserved at this level
  logic big_page; // entry maps a 1-GByte page
  logic refuse; // rights refuse the access
  logic wr_ok_all; // write permission including this entry
  logic usr_ok_all; // user permission including this entry
  logic nx_all; // no-execute including this entry

  // entry checker shared by all levels
  flpw_entry_chk u_chk (
    .entry(mem_rdata),
    .phys_width(phys_addr_width),
    .nx_enable(no_execute_enable),
    .size_rsvd(size_rsvd),
    .big_page(big_page),
    .bad(chk_bad),
    .wr_ok(chk_wr),
    .usr_ok(chk_usr),
    .nx(chk_nx)
  );

  // index and level-dependent checks
  always_comb begin
    addr_mask = (52'h1 << phys_addr_width) - 52'h1; // R6
    case (s_reg.st)
      flpw_pkg::FLPW_TOP: idx = s_reg.rq.lin_addr[47:39]; // R8
      flpw_pkg::FLPW_THIRD: idx = s_reg.rq.lin_addr[38:30]; // R10
      default: idx = s_reg.rq.lin_addr[29:21]; // R12
    endcase
    size_rsvd = (s_reg.st == flpw_pkg::FLPW_TOP) // R14
      || ((s_reg.st == flpw_pkg::FLPW_THIRD) && !GIG_PAGES); // R13 R7
    big_page = (s_reg.st == flpw_pkg::FLPW_THIRD) && GIG_PAGES
      && mem_rdata[flpw_pkg::ENT_SIZE_BIT]; // R20
    wr_ok_all = s_reg.wr_ok & chk_wr;
    usr_ok_all = s_reg.usr_ok & chk_usr;
    nx_all = s_reg.nx | chk_nx;
    // write refused when not allowed and user or protected supervisor
    refuse = (s_reg.rq.is_write && !wr_ok_all
              && ((s_reg.rq.priv_level == flpw_pkg::USER_LEVEL)
                  || supervisor_write_protect)) // R15
      || ((s_reg.rq.priv_level == flpw_pkg::USER_LEVEL) && !usr_ok_all) // R16
      || (s_reg.rq.is_fetch && nx_all); // R18
  end

  // next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.out_valid = 1'b0;
    // root pointer write
    if (root_wr) begin
      s_next.root = root_wdata;
    end
    case (s_reg.st)
      flpw_pkg::FLPW_IDLE: begin
        if (req_valid && walker_active) begin // R1
          s_next.rq = req; // R2
          s_next.base = {s_reg.root[51:12], 12'h000} & addr_mask; // R3 R4 R9
          // tagged layout: bits 4:3 are part of the tag, not attributes
          s_next.wr_thru = context_tag_enable ? 1'b0
            : s_reg.root[flpw_pkg::ROOT_WT_BIT]; // R3 R5
          s_next.cache_off = context_tag_enable ? 1'b0
            : s_reg.root[flpw_pkg::ROOT_CD_BIT]; // R3 R5
          s_next.wr_ok = 1'b1;
          s_next.usr_ok = 1'b1;
          s_next.nx = 1'b0;
          s_next.issued = 1'b0;
          s_next.st = flpw_pkg::FLPW_TOP;
        end else if (req_valid) begin
          // walker not in use: report fault at top level
          s_next.out = '0;
          s_next.out.fault = 1'b1;
          s_next.out.fault_level = flpw_pkg::LVL_TOP;
          s_next.out_valid = 1'b1;
        end
      end
      flpw_pkg::FLPW_TOP, flpw_pkg::FLPW_THIRD, flpw_pkg::FLPW_DIR: begin
        if (!s_reg.issued) begin
          if (mem_ready) begin
            s_next.issued = 1'b1;
          end
        end else if (mem_rvalid) begin
          s_next.issued = 1'b0;
          s_next.wr_ok = wr_ok_all;
          s_next.usr_ok = usr_ok_all;
          s_next.nx = nx_all;
          s_next.base = {mem_rdata[51:12], 12'h000} & addr_mask; // R10 R12 R6
          s_next.wr_thru = mem_rdata[flpw_pkg::ENT_WT_BIT]; // R19
          s_next.cache_off = mem_rdata[flpw_pkg::ENT_CD_BIT]; // R19
          s_next.out = '0;
          s_next.out.fault_level = (s_reg.st == flpw_pkg::FLPW_TOP) ? flpw_pkg::LVL_TOP
            : (s_reg.st == flpw_pkg::FLPW_THIRD) ? flpw_pkg::LVL_THIRD
            : flpw_pkg::LVL_DIR; // R22
          if (chk_bad) begin
            s_next.out.fault = 1'b1; // R22
            s_next.st = flpw_pkg::FLPW_FAULT;
          end else if (big_page) begin
            // 1-GByte page: entry bits 51:30, linear 29:0
            s_next.out.phys_addr = {mem_rdata[51:30], s_reg.rq.lin_addr[29:0]}
              & addr_mask; // R11 R6
            s_next.out.page_size = 2'h2;
            s_next.out.denied = refuse;
            s_next.st = flpw_pkg::FLPW_DONE;
          end else if ((s_reg.st == flpw_pkg::FLPW_DIR)
                       && mem_rdata[flpw_pkg::ENT_SIZE_BIT]) begin
            // 2-MByte page mapped by the directory entry
            s_next.out.phys_addr = {mem_rdata[51:21], s_reg.rq.lin_addr[20:0]}
              & addr_mask; // R21 R6
            s_next.out.page_size = 2'h1;
            s_next.out.denied = refuse;
            s_next.st = flpw_pkg::FLPW_DONE;
          end else if (s_reg.st == flpw_pkg::FLPW_DIR) begin
            // 4-KByte page needs the lowest level, outside this walker
            s_next.out.phys_addr = {mem_rdata[51:12], 12'h000} & addr_mask;
            s_next.out.page_size = 2'h0;
            s_next.out.denied = refuse;
            s_next.st = flpw_pkg::FLPW_DONE; // R7
          end else begin
            s_next.st = (s_reg.st == flpw_pkg::FLPW_TOP) ? flpw_pkg::FLPW_THIRD
              : flpw_pkg::FLPW_DIR; // R12
          end
        end
      end
      flpw_pkg::FLPW_DONE, flpw_pkg::FLPW_FAULT: begin
        s_next.out_valid = 1'b1;
        s_next.st = flpw_pkg::FLPW_IDLE;
      end
      default: begin
        s_next.st = flpw_pkg::FLPW_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs
  always_comb begin
    walker_active = paging_enable & extended_addr_enable & long_mode_enable; // R1
    root_pointer_reg = s_reg.root;
    // context tag reads zero as soon as tagging is off
    context_tag = context_tag_enable ? s_reg.root[11:0] : 12'h000; // R4 R5
    req_ready = (s_reg.st == flpw_pkg::FLPW_IDLE);
    rsp_valid = s_reg.out_valid;
    rsp = s_reg.out;
    mem_valid = ((s_reg.st == flpw_pkg::FLPW_TOP) || (s_reg.st == flpw_pkg::FLPW_THIRD)
                 || (s_reg.st == flpw_pkg::FLPW_DIR)) && !s_reg.issued;
    mem.addr = (s_reg.base | {40'h00_0000_0000, idx, 3'h0}) & addr_mask; // R8 R9 R6
    mem.wr_thru = s_reg.wr_thru;
    mem.cache_off = s_reg.cache_off;
    mem.set_accessed = 1'b1; // R17
  end
endmodule : flpw_walker

// ### verification/flpw_mem_model.sv
// memory holding the paging tables, answering entry fetches
`timescale 1ns/1ns
module flpw_mem_model (
  input wire logic clk_sys, // clock
  input wire logic mem_valid, // fetch request
  input wire flpw_pkg::flpw_mem_s mem, // fetch address
  output logic mem_ready, // fetch taken
  output logic mem_rvalid, // entry returned
  output logic [63:0] mem_rdata // entry data
);
  logic [63:0] tbl [logic [51:0]]; // table contents, unmapped reads zero
  logic [51:0] a; // address of the fetch in flight
  int seed = 32'h06cb; // stall seed
  // answer each fetch after random stalls; data toggles each cycle while no fetch is in progress
  initial begin
    mem_ready = 0;
    mem_rvalid = 0;
    mem_rdata = 64'h5555_5555_5555_5555;
    forever begin
      @(posedge clk_sys);
      #1;
      mem_rvalid = 0;
      mem_rdata = ~mem_rdata;
      if (mem_valid === 1'b1) begin
        repeat ($unsigned($random(seed)) % 3) begin
          @(posedge clk_sys);
          #1;
        end
        a = mem.addr;
        mem_ready = 1;
        @(posedge clk_sys);
        #1;
        mem_ready = 0;
        repeat ($unsigned($random(seed)) % 3) begin
          @(posedge clk_sys);
          #1;
        end
        mem_rvalid = 1;
        mem_rdata = tbl.exists(a) ? tbl[a] : 64'h0;
      end
    end
  end
endmodule : flpw_mem_model

// ### verification/flpw_walker_asserts.sv
// assertion checker watching the page walker ports
`timescale 1ns/1ns
module flpw_walker_asserts (
  input wire logic clk_sys, // clock
  input wire logic rst_b, // reset, active low
  input wire logic paging_enable, // enable one
  input wire logic extended_addr_enable, // enable two
  input wire logic long_mode_enable, // enable three
  input wire logic context_tag_enable, // root layout select
  input wire logic [5:0] phys_addr_width, // physical width
  input wire logic root_wr, // root write strobe
  input wire logic [63:0] root_wdata, // root write data
  input wire logic [63:0] root_pointer_reg, // root readback
  input wire logic [11:0] context_tag, // current tag
  input wire logic walker_active, // scheme in use
  input wire logic req_valid, // request
  input wire logic req_ready, // request accepted
  input wire flpw_pkg::flpw_req_s req, // request fields
  input wire logic rsp_valid, // result pulse
  input wire flpw_pkg::flpw_rsp_s rsp, // result fields
  input wire logic mem_valid, // fetch request
  input wire logic mem_ready, // fetch taken
  input wire flpw_pkg::flpw_mem_s mem, // fetch fields
  input wire logic mem_rvalid, // entry returned
  input wire logic [63:0] mem_rdata // entry data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // a request taken by the walker
  sequence s_take;
    req_valid && req_ready;
  endsequence
  // first fetch: top table entry with root attributes
  sequence s_top;
    mem_valid && mem.addr[51:12] == root_pointer_reg[51:12]
    && mem.addr[11:0] == {$past(req.lin_addr[47:39]), 3'h0}
    && mem.wr_thru == (!context_tag_enable && root_pointer_reg[3])
    && mem.cache_off == (!context_tag_enable && root_pointer_reg[4]);
  endsequence
  active_decode_a:
    assert property (walker_active == (paging_enable && extended_addr_enable
      && long_mode_enable)) else $error("active flag wrong");
  idle_fault_a:
    assert property (s_take ##0 !walker_active |=> rsp_valid && rsp.fault
      && rsp.fault_level == 2'h0) else $error("inactive request not faulted");
  root_load_a:
    assert property (root_wr |=> root_pointer_reg == $past(root_wdata))
      else $error("root not loaded");
  tag_view_a:
    assert property (context_tag == (context_tag_enable ? root_pointer_reg[11:0] : 12'h000))
      else $error("context tag wrong");
  top_fetch_a:
    assert property (s_take ##0 walker_active |=> s_top) else $error("top fetch wrong");
  phys_zero_a:
    assert property (mem_valid |-> (mem.addr >> phys_addr_width) == 52'h0)
      else $error("fetch above width");
  rsp_zero_a:
    assert property (rsp_valid && !rsp.fault |-> (rsp.phys_addr >> phys_addr_width) == 52'h0)
      else $error("result above width");
  entry_align_a:
    assert property (mem_valid |-> mem.addr[2:0] == 3'h0 && mem.set_accessed)
      else $error("fetch misaligned or unmarked");
  fetch_wait_a:
    assert property (mem_valid && mem_ready |=> !mem_valid until_with mem_rvalid)
      else $error("fetch while waiting");
  walk_done_a:
    assert property (s_take |-> ##[1:60] rsp_valid) else $error("walk never ended");
  next_attr_a:
    assert property (mem_rvalid |=> !mem_valid
      || (mem.wr_thru == $past(mem_rdata[3]) && mem.cache_off == $past(mem_rdata[4])))
      else $error("next fetch attributes wrong");
endmodule : flpw_walker_asserts
bind flpw_walker flpw_walker_asserts i_chk (.clk_sys, .rst_b, .paging_enable,
  .extended_addr_enable, .long_mode_enable, .context_tag_enable, .phys_addr_width,
  .root_wr, .root_wdata, .root_pointer_reg, .context_tag, .walker_active, .req_valid,
  .req_ready, .req, .rsp_valid, .rsp, .mem_valid, .mem_ready, .mem, .mem_rvalid, .mem_rdata);

// ### verification/flpw_walker_tb.sv
// self-checking testbench for the four-level page walker
`timescale 1ns/1ns
module flpw_walker_tb;
  localparam logic [63:0] RT = 64'h0000_0000_0000_1000; // top table base
  localparam logic [63:0] TP = 64'h0000_0000_0000_201f; // top entry, attributes set
  localparam logic [63:0] DP = 64'h0000_0000_0000_3007; // third entry to directory
  localparam logic [63:0] GP = 64'h0000_000c_4000_0087; // 1-GByte leaf
  localparam logic [63:0] MP = 64'h0000_0000_0660_0087; // 2-MByte leaf
  localparam logic [63:0] NX = 64'h8000_0000_0000_0000; // no-execute bit
  logic clk_sys = 0, rst_b = 0, cte = 0, nxe = 0, root_wr = 0, req_valid = 0, wp = 1;
  logic [2:0] en = 3'h7; // the three enables
  logic [5:0] phys_addr_width = 6'h34; // physical width
  logic [63:0] root_wdata = 64'h0, root_pointer_reg, mem_rdata;
  logic [11:0] context_tag;
  logic walker_active, req_ready, rsp_valid, mem_valid, mem_ready, mem_rvalid;
  flpw_pkg::flpw_req_s req = '0;
  flpw_pkg::flpw_rsp_s rsp, e;
  flpw_pkg::flpw_mem_s mem;
  flpw_pkg::flpw_rsp_s exq[$]; // expected results, oldest first
  int n_fail = 0, checks_done = 0, seed = 32'h06cb;
  flpw_walker i_dut (.clk_sys, .rst_b, .paging_enable(en[0]), .extended_addr_enable(en[1]),
    .long_mode_enable(en[2]), .context_tag_enable(cte), .no_execute_enable(nxe),
    .supervisor_write_protect(wp), .phys_addr_width, .root_wr, .root_wdata,
    .root_pointer_reg, .context_tag, .walker_active, .req_valid, .req_ready, .req,
    .rsp_valid, .rsp, .mem_valid, .mem_ready, .mem, .mem_rvalid, .mem_rdata);
  flpw_mem_model i_mem (.clk_sys, .mem_valid, .mem, .mem_ready, .mem_rvalid, .mem_rdata);
  // compare one value and count it
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] ex);
    checks_done++;
    if (seen !== ex) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk
  // verdict and end of run
  task stop_test;
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  // expected result record
  function automatic flpw_pkg::flpw_rsp_s ex(logic [51:0] pa, logic [1:0] sz, logic f, d,
    logic [1:0] lv);
    ex = '{pa, sz, f, d, lv};
  endfunction : ex
  // lay out the three entries for a random address, request it, wait for the result
  task automatic walk(logic [63:0] e0, e1, e2, logic [3:0] acc, flpw_pkg::flpw_rsp_s x);
    logic [47:0] la;
    la = 48'({$random(seed), $random(seed)});
    i_mem.tbl[{RT[51:12], la[47:39], 3'h0}] = e0;
    i_mem.tbl[{e0[51:12], la[38:30], 3'h0}] = e1;
    i_mem.tbl[{e1[51:12], la[29:21], 3'h0}] = e2;
    if (x.page_size == 2'h2) x.phys_addr[29:0] = la[29:0];
    if (x.page_size == 2'h1) x.phys_addr[20:0] = la[20:0];
    exq.push_back(x);
    req = '{la, acc[2], acc[3], acc[1:0]};
    req_valid = 1;
    do @(posedge clk_sys); while (req_ready !== 1'b1);
    #1 req_valid = 0;
    for (int k = 0; k < 60 && rsp_valid !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    #1;
  endtask : walk
  // result monitor: each pulse is matched with the oldest expectation
  initial forever begin
    @(posedge clk_sys);
    if (rsp_valid === 1'b1) begin
      e = exq.pop_front();
      chk("fault", rsp.fault, e.fault);
      chk("level", rsp.fault_level, e.fault_level);
      chk("denied", rsp.denied, e.denied);
      if (!e.fault && !e.denied) begin
        chk("phys", rsp.phys_addr, e.phys_addr);
        chk("size", rsp.page_size, e.page_size);
      end
    end
  end
  // clock at 100 ns
  initial forever #50 clk_sys = ~clk_sys;
  // watchdog
  initial begin
    #400000;
    n_fail++;
    stop_test;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 rst_b = 1;
    root_wdata = RT | 64'h18;
    root_wr = 1;
    @(posedge clk_sys);
    #1 root_wr = 0;
    chk("root", root_pointer_reg, RT | 64'h18);
    cte = 1;
    @(posedge clk_sys);
    #1 chk("tag", context_tag, 12'h018);
    walk(TP, GP, 0, 4'h0, ex(GP[51:0], 2'h2, 0, 0, 2'h1));
    cte = 0;
    @(posedge clk_sys);
    #1 chk("tag off", context_tag, 12'h000);
    repeat (3) begin
      walk(TP, GP, 0, 4'h0, ex(GP[51:0], 2'h2, 0, 0, 2'h1));
      walk(TP, DP, MP, 4'h3, ex(MP[51:0], 2'h1, 0, 0, 2'h2));
      walk(TP, DP, 64'h5007, 4'h4, ex(52'h5000, 2'h0, 0, 0, 2'h2));
    end
    walk(0, GP, 0, 4'h0, ex(0, 0, 1, 0, 2'h0));
    walk(TP | 64'h80, GP, 0, 4'h0, ex(0, 0, 1, 0, 2'h0));
    walk(TP | NX, GP, 0, 4'h0, ex(0, 0, 1, 0, 2'h0));
    walk(TP, 0, 0, 4'h0, ex(0, 0, 1, 0, 2'h1));
    walk(TP, GP | 64'h2000, 0, 4'h0, ex(0, 0, 1, 0, 2'h1));
    walk(TP, DP, 0, 4'h0, ex(0, 0, 1, 0, 2'h2));
    walk(TP & ~64'h4, GP, 0, 4'h3, ex(0, 0, 0, 1, 2'h1));
    walk(TP, GP & ~64'h2, 0, 4'h4, ex(0, 0, 0, 1, 2'h1));
    wp = 0;
    walk(TP, GP & ~64'h2, 0, 4'h4, ex(GP[51:0], 2'h2, 0, 0, 2'h1));
    wp = 1;
    nxe = 1;
    walk(TP | NX, GP, 0, 4'h8, ex(0, 0, 0, 1, 2'h1));
    phys_addr_width = 6'h28;
    walk(TP, GP | 64'h2000_0000_0000, 0, 4'h0, ex(0, 0, 1, 0, 2'h1));
    phys_addr_width = 6'h34;
    for (int b = 0; b < 3; b++) begin
      en = 3'h7 ^ (3'h1 << b);
      walk(TP, GP, 0, 4'h0, ex(0, 0, 1, 0, 2'h0));
    end
    chk("queue", 64'(exq.size()), 64'h0);
    stop_test;
  end
endmodule : flpw_walker_tb
